// ===== core/hia_aggregator.sv
// Functional notes
// - output disabled: request pin left undriven
// - enabled: pin low when masked flags nonzero
// - mask one enables flag, zero blocks
// - each flag set by its own source
// - flag read returns flags, then clears those with no same-cycle event
// - bits 7..4: touch conv, queue flag, drained, playback
// - bits 3..0: sound, tag change, touch, swap
`timescale 1ns/100ps
`default_nettype none
module hia_aggregator
  import hia_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       touch_conversion_done,
  input  wire logic       command_queue_flag,
  input  wire logic       command_queue_drained,
  input  wire logic       playback_ended,
  input  wire logic       sound_ended,
  input  wire logic       tag_changed,
  input  wire logic       touch_detected,
  input  wire logic       list_swapped,
  input  wire logic       flags_rd,
  output logic [7:0]      flags_rdata,
  input  wire logic       mask_wr,
  input  wire logic [7:0] mask_wdata,
  output logic [7:0]      mask_rdata,
  input  wire logic       int_en_wr,
  input  wire logic       int_en_wdata,
  output logic            int_en_rdata,
  input  wire logic       int_n_i,
  output logic            int_n_o,
  output logic            int_n_oe
);
  import hia_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic       en;
    logic [7:0] rdata;
    logic       oe;
  } hia_state_t;

  hia_state_t state_reg;
  hia_state_t state_next;
  logic [7:0] events;
  logic       unused_pin;

  assign unused_pin = int_n_i;

  // ---------------------------------------------------------------
  // event mapping
  // ---------------------------------------------------------------
  always_comb begin
    events = 8'h00;
    events[HIA_BIT_TOUCH_CONVERSION_DONE] = touch_conversion_done;
    events[HIA_BIT_COMMAND_QUEUE_FLAG]    = command_queue_flag;
    events[HIA_BIT_COMMAND_QUEUE_DRAINED] = command_queue_drained;
    events[HIA_BIT_PLAYBACK_ENDED]        = playback_ended;
    events[HIA_BIT_SOUND_ENDED]           = sound_ended;
    events[HIA_BIT_TAG_CHANGED]           = tag_changed;
    events[HIA_BIT_TOUCH_DETECTED]        = touch_detected;
    events[HIA_BIT_LIST_SWAPPED]          = list_swapped;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (mask_wr) begin
      state_next.mask = mask_wdata;
    end
    if (int_en_wr) begin
      state_next.en = int_en_wdata;
    end
    // read captures current flags; clear loses to a same-cycle set
    if (flags_rd) begin
      state_next.rdata = state_reg.flags;
      state_next.flags = events;
    end else begin
      state_next.flags = state_reg.flags | events;
    end
    // pin decided from next state so it tracks flags with no lag
    state_next.oe = state_next.en &&
                    ((state_next.flags & state_next.mask) != 8'h00);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg.flags <= HIA_FLAGS_RST;
      state_reg.mask  <= HIA_MASK_RST;
      state_reg.en    <= HIA_EN_RST;
      state_reg.rdata <= 8'h00;
      state_reg.oe    <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign flags_rdata  = state_reg.rdata;
  assign mask_rdata   = state_reg.mask;
  assign int_en_rdata = state_reg.en;
  assign int_n_o      = 1'b0;
  assign int_n_oe     = state_reg.oe;

  // ---------------------------------------------------------------
  // pin and register write checks
  // ---------------------------------------------------------------
  a_pin_undriven_off: assert property (
    @(posedge clk_sys) disable iff (rst)
    !state_reg.en |-> !int_n_oe)
    else $error("pin driven while off");
  a_pin_follows_flags: assert property (
    @(posedge clk_sys) disable iff (rst)
    int_n_oe == (state_reg.en && |(state_reg.flags & state_reg.mask)))
    else $error("pin state wrong");
  a_mask_blocks_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    ((state_reg.flags & state_reg.mask) == 8'h00) |-> !int_n_oe)
    else $error("masked flag drove pin");
  a_pin_pulls_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    int_n_oe |-> !int_n_o)
    else $error("pin not pulled low");
  a_enable_write_lands: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && int_en_wr) |=> int_en_rdata == $past(int_en_wdata))
    else $error("enable write lost");
  a_mask_write_lands: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && mask_wr) |=> mask_rdata == $past(mask_wdata))
    else $error("mask write lost");

  // ---------------------------------------------------------------
  // flag checks
  // ---------------------------------------------------------------
  a_event_sets_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && events[0]) |=> state_reg.flags[0])
    else $error("event lost");
  a_read_clears_flags: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && flags_rd && events == 8'h00) |=> state_reg.flags == 8'h00)
    else $error("read did not clear");
  a_read_returns_flags: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && flags_rd) |=> flags_rdata == $past(state_reg.flags))
    else $error("read data wrong");
  a_read_data_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(clk_en && flags_rd) |=> $stable(flags_rdata))
    else $error("read data moved without read");
  a_set_beats_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && flags_rd && tag_changed) |=> state_reg.flags[2])
    else $error("event lost on read");

  // ---------------------------------------------------------------
  // source to bit map
  // ---------------------------------------------------------------
  a_top_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && touch_conversion_done) |=> state_reg.flags[7])
    else $error("bit 7 not set");
  a_queue_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && command_queue_flag) |=> state_reg.flags[6])
    else $error("bit 6 not set");
  a_drained_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && command_queue_drained) |=> state_reg.flags[5])
    else $error("bit 5 not set");
  a_playback_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && playback_ended) |=> state_reg.flags[4])
    else $error("bit 4 not set");
  a_low_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && sound_ended) |=> state_reg.flags[3])
    else $error("bit 3 not set");
  a_tag_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && tag_changed) |=> state_reg.flags[2])
    else $error("bit 2 not set");
  a_touch_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && touch_detected) |=> state_reg.flags[1])
    else $error("bit 1 not set");
  a_swap_bit_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (clk_en && list_swapped) |=> state_reg.flags[0])
    else $error("bit 0 not set");

  // ---------------------------------------------------------------
  // clock enable and reset
  // ---------------------------------------------------------------
  a_freeze_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    !clk_en |=> $stable(state_reg))
    else $error("state moved while frozen");
  a_reset_state: assert property (
    @(posedge clk_sys)
    rst |=> (state_reg.flags == HIA_FLAGS_RST &&
             mask_rdata == HIA_MASK_RST &&
             int_en_rdata == HIA_EN_RST &&
             flags_rdata == 8'h00 && !int_n_oe))
    else $error("reset state wrong");

  // ---------------------------------------------------------------
  // per-bit checks
  // ---------------------------------------------------------------
  for (genvar b = 0; b < HIA_NUM_SRC; b++) begin : g_bit_chk
    a_bit_event_sets: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && events[b]) |=> state_reg.flags[b])
      else $error("flag not set by its event");
    a_bit_flag_sticks: assert property (
      @(posedge clk_sys) disable iff (rst)
      (!(clk_en && flags_rd) && state_reg.flags[b]) |=> state_reg.flags[b])
      else $error("flag dropped without read");
    a_bit_no_stray: assert property (
      @(posedge clk_sys) disable iff (rst)
      (!state_reg.flags[b] && !(clk_en && events[b])) |=> !state_reg.flags[b])
      else $error("flag set without its event");
    a_bit_read_clears: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && flags_rd && !events[b]) |=> !state_reg.flags[b])
      else $error("flag kept after read");
    a_bit_set_wins: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && flags_rd && events[b]) |=> state_reg.flags[b])
      else $error("event lost on read");
    a_bit_mask_enables: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state_reg.en && state_reg.mask[b] && state_reg.flags[b]) |-> int_n_oe)
      else $error("enabled flag did not drive pin");
  end
endmodule
`default_nettype wire

// ===== core/hia_pkg.sv
`default_nettype none
package hia_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned HIA_NUM_SRC = 8;
  localparam logic [7:0] HIA_FLAGS_RST = 8'h00;
  localparam logic [7:0] HIA_MASK_RST  = 8'hFF;
  localparam logic       HIA_EN_RST    = 1'b0;
  // ---------------------------------------------------------------
  // flag bit positions
  // ---------------------------------------------------------------
  localparam int unsigned HIA_BIT_TOUCH_CONVERSION_DONE = 7;
  localparam int unsigned HIA_BIT_COMMAND_QUEUE_FLAG    = 6;
  localparam int unsigned HIA_BIT_COMMAND_QUEUE_DRAINED = 5;
  localparam int unsigned HIA_BIT_PLAYBACK_ENDED        = 4;
  localparam int unsigned HIA_BIT_SOUND_ENDED           = 3;
  localparam int unsigned HIA_BIT_TAG_CHANGED           = 2;
  localparam int unsigned HIA_BIT_TOUCH_DETECTED        = 1;
  localparam int unsigned HIA_BIT_LIST_SWAPPED          = 0;
endpackage
`default_nettype wire

// ===== verification/hia_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hia_host_model (
  input  wire logic oe,
  input  wire logic drv,
  output logic      pin_n
);
  // pull-up takes the line whenever the device lets go
  assign pin_n = oe ? drv : 1'b1;
endmodule
`default_nettype wire

// ===== verification/host_interrupt_aggregator_test.sv
`timescale 1ns/100ps
`default_nettype none
module host_interrupt_aggregator_test;
  logic        clk_sys, rst, clk_en, flags_rd, mask_wr, int_en_wr;
  logic        int_en_wdata, int_en_rdata, int_n_o, int_n_oe, pin_n, xo;
  logic [7:0]  ev, mask_wdata, flags_rdata, mask_rdata;
  logic [31:0] r;
  int          flg, msk, en, rdv, failures, samples_checked;
  hia_aggregator hia_aggregator_inst (.clk_sys, .rst, .clk_en,
    .touch_conversion_done(ev[7]), .command_queue_flag(ev[6]),
    .command_queue_drained(ev[5]), .playback_ended(ev[4]),
    .sound_ended(ev[3]), .tag_changed(ev[2]), .touch_detected(ev[1]),
    .list_swapped(ev[0]), .flags_rd, .flags_rdata, .mask_wr, .mask_wdata,
    .mask_rdata, .int_en_wr, .int_en_wdata, .int_en_rdata,
    .int_n_i(pin_n), .int_n_o, .int_n_oe);
  hia_host_model hia_host_model_inst (.oe(int_n_oe), .drv(int_n_o),
    .pin_n);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // run needs about 2020 cycles; margin for slack
  initial begin
    #12000;
    failures++;
    finish_test();
  end
  initial begin
    {flags_rd, mask_wr, int_en_wr, int_en_wdata, ev, mask_wdata} = '0;
    clk_en = 1;
    rst = 1;
    r = 32'hE4D8;
    msk = hia_pkg::HIA_MASK_RST;
    repeat (16) @(negedge clk_sys);
    rst = 0;
    for (int i = 0; i < 2000; i++) begin
      xo = en != 0 && (flg & msk) != 0;
      chk(flags_rdata, rdv[7:0]);
      chk(mask_rdata, msk[7:0]);
      chk({7'h00, int_n_oe}, {7'h00, xo});
      chk({7'h00, pin_n}, {7'h00, !xo});
      chk({7'h00, int_en_rdata}, en[7:0]);
      // fresh bits each cycle, else events trail the shift
      repeat (8) r = lfsr(r);
      ev = r[7:0] & r[15:8] & r[23:16];
      flags_rd = r[24] & r[25];
      mask_wr = r[26] & r[27];
      mask_wdata = r[15:8];
      int_en_wr = r[28] & r[29];
      int_en_wdata = r[30] | r[31];
      clk_en = r[31] | r[29] | r[3];
      // one-cycle mid-run reset, clock enable left random
      rst = i == 1000;
      if (rst) begin
        flg = hia_pkg::HIA_FLAGS_RST;
        msk = hia_pkg::HIA_MASK_RST;
        en = hia_pkg::HIA_EN_RST;
        rdv = 0;
      end else if (clk_en) begin
        if (flags_rd) rdv = flg;
        flg = (flags_rd ? 0 : flg) | ev;
        if (mask_wr) msk = mask_wdata;
        if (int_en_wr) en = int_en_wdata;
      end
      @(negedge clk_sys);
    end
    finish_test();
  end
endmodule
`default_nettype wire
